//--- src/ths_sensor_port.sv
// serial command and readout engine of the sensor's two-wire port
// assumes host-driven sck and open-drain data, pins sampled on sys_clk
`timescale 1ns/10ps
`include "ths_consts.svh"

module ths_sensor_port #(
  parameter int unsigned WAKE_CYC = `THS_T_WAKE_MS * `THS_CYC_PER_MS,
  parameter int unsigned MEAS8_CYC = `THS_T_MEAS8_MS * `THS_CYC_PER_MS,
  parameter int unsigned MEAS12_CYC = `THS_T_MEAS12_MS * `THS_CYC_PER_MS,
  parameter int unsigned MEAS14_CYC = `THS_T_MEAS14_MS * `THS_CYC_PER_MS,
  parameter int unsigned EARLY_PCT = 0,
  parameter int FIFO_DEPTH = `THS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // serial pins
  input wire logic sck_pin,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  // conversion front end
  input wire logic [13:0] tmp_raw,
  input wire logic [11:0] hum_raw,
  input wire logic supply_low_in,
  input wire logic [7:0] checksum_in,
  // status and activity
  output logic heater_on,
  output logic otp_reload_off,
  output logic res_low,
  output logic meas_busy,
  output ths_pkg::ths_meas_t meas_kind
);
  import ths_pkg::*;

  localparam int CW = 26;
  // products stay below 2**32 for the documented figures
  localparam int unsigned KEEP_PCT = 100 - EARLY_PCT;
  localparam int unsigned M8 = MEAS8_CYC / 100 * KEEP_PCT;
  localparam int unsigned M12 = MEAS12_CYC / 100 * KEEP_PCT;
  localparam int unsigned M14 = MEAS14_CYC / 100 * KEEP_PCT;

  // ==========================================================
  // parameter checks
  generate
    if (EARLY_PCT > `THS_EARLY_MAX_PCT || M8 < 1 || WAKE_CYC < 1 ||
        M14 >= (1 << CW) || WAKE_CYC >= (1 << CW) || M8 > M12 || M12 > M14)
    begin : g_bad_param
      $error("ths_sensor_port: timing parameters out of range");
    end
  endgenerate

  // ==========================================================
  // helpers
  // conversion length by kind and resolution
  function automatic logic [CW-1:0] meas_cycles(input ths_meas_t k, input logic lo);
    logic [CW-1:0] c;
    c = CW'(M14 - 1);
    if (k == MK_HUM)
      c = lo ? CW'(M8 - 1) : CW'(M12 - 1);
    else
      c = lo ? CW'(M12 - 1) : CW'(M14 - 1);
    return c;
  endfunction

  // right-justified result word
  function automatic logic [15:0] fmt_result(input ths_meas_t k, input logic lo,
                                             input logic [11:0] h, input logic [13:0] t);
    logic [15:0] r;
    r = 16'h0000;
    if (k == MK_HUM)
      r = lo ? {8'h00, h[11:4]} : {4'h0, h};
    else
      r = lo ? {4'h0, t[13:2]} : {2'h0, t};
    return r;
  endfunction

  // status byte as read back
  function automatic logic [7:0] stat_byte(input logic [3:0] w, input logic lv);
    logic [7:0] b;
    b = 8'h00;
    b[`THS_ST_RES] = w[`THS_ST_RES];
    b[`THS_ST_OTP] = w[`THS_ST_OTP];
    b[`THS_ST_HEAT] = w[`THS_ST_HEAT];
    b[`THS_ST_TEST] = w[`THS_ST_TEST];
    b[`THS_ST_LOWV] = lv;
    return b;
  endfunction

  // accepted command bytes
  function automatic logic cmd_ok(input logic [7:0] c);
    logic ok;
    ok = 1'b0;
    if (c[7:5] == `THS_ADDR_OK)
    begin
      case (c[4:0])
        `THS_CMD_TEMP, `THS_CMD_HUM: ok = 1'b1;
        `THS_CMD_STAT_RD, `THS_CMD_STAT_WR: ok = 1'b1;
        `THS_CMD_SOFT_RST: ok = 1'b1;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // ==========================================================
  // pin synchronisers and edges
  logic sck_m_ff, sck_s_ff, sck_q_ff;
  logic dat_m_ff, dat_s_ff, dat_q_ff;

  // two stages, then a history stage for edges
  always_ff @(posedge sys_clk)
  begin
    sck_m_ff <= sck_pin;
    sck_s_ff <= sck_m_ff;
    sck_q_ff <= sck_s_ff;
    dat_m_ff <= data_pin_in;
    dat_s_ff <= dat_m_ff;
    dat_q_ff <= dat_s_ff;
  end

  wire sck_rise = sck_s_ff && !sck_q_ff;
  wire sck_fall = !sck_s_ff && sck_q_ff;
  wire dat_rise = dat_s_ff && !dat_q_ff;
  wire dat_fall = !dat_s_ff && dat_q_ff;

  // ==========================================================
  // state
  ths_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic oe_ff, nxt_oe;
  logic [CW-1:0] tmr_ff, nxt_tmr;
  logic [3:0] st_ff, nxt_st;
  logic lowv_ff, nxt_lowv;
  ths_meas_t kind_ff, nxt_kind;
  logic [15:0] res_ff, nxt_res;
  logic [1:0] ld_idx_ff, nxt_ld_idx;
  logic ack_ff, nxt_ack;
  logic busy_ff;
  logic dout_ff;
  logic [1:0] ts_ph_ff, nxt_ts_ph;
  logic [3:0] crst_ff, nxt_crst;
  logic q_rready, q_flush;

  ths_fifo_if #(.WIDTH(`THS_FIFO_WIDTH)) q_if();

  // ==========================================================
  // transfer-begin tracker, only while the line is ours to watch
  logic transfer_begin_sequence;
  always_comb
  begin
    nxt_ts_ph = ts_ph_ff;
    transfer_begin_sequence = 1'b0;
    if (oe_ff)
      nxt_ts_ph = 2'h0;
    else
    begin
      case (ts_ph_ff)
        2'h0: if (dat_fall && sck_s_ff) nxt_ts_ph = 2'h1;
        2'h1:
        begin
          if (sck_fall)
            nxt_ts_ph = 2'h2;
          else if (dat_rise)
            nxt_ts_ph = 2'h0;
        end
        2'h2:
        begin
          if (dat_rise && sck_s_ff)
          begin
            transfer_begin_sequence = 1'b1;
            nxt_ts_ph = 2'h0;
          end
          else if (sck_rise && dat_s_ff)
            nxt_ts_ph = 2'h0;
        end
        default: nxt_ts_ph = 2'h0;
      endcase
    end
  end

  // connection reset: count rising sck with data high
  wire crst_hit = sck_rise && dat_s_ff && (crst_ff == `THS_CONN_RST_CNT - 4'h1);
  assign nxt_crst = !sck_rise ? crst_ff : (!dat_s_ff || crst_hit) ? 4'h0 : crst_ff + 4'h1;

  // ==========================================================
  // buffer loading
  wire [1:0] ld_last = (kind_ff == MK_STAT) ? `THS_LD_LAST_STAT : `THS_LD_LAST_MEAS;
  wire [7:0] ld_first = (kind_ff == MK_STAT) ? stat_byte(st_ff, lowv_ff) : res_ff[15:8];
  wire [7:0] ld_second = (kind_ff == MK_STAT) ? checksum_in : res_ff[7:0];
  assign q_if.wvalid = (state_ff == ST_LOAD);
  assign q_if.wdata = (ld_idx_ff == 2'h0) ? ld_first :
                      (ld_idx_ff == 2'h1) ? ld_second : checksum_in;
  assign q_if.rready = q_rready;
  assign q_if.flush = q_flush;

  ths_fifo #(.WIDTH(`THS_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .q(q_if.fill)
  );

  // ==========================================================
  // serial engine next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_oe = oe_ff;
    nxt_tmr = tmr_ff;
    nxt_st = st_ff;
    nxt_lowv = lowv_ff;
    nxt_kind = kind_ff;
    nxt_res = res_ff;
    nxt_ld_idx = ld_idx_ff;
    nxt_ack = ack_ff;
    q_rready = 1'b0;
    q_flush = 1'b0;
    case (state_ff)
      // quiet time after power-up or soft reset
      ST_WAKE:
      begin
        if (tmr_ff == '0)
          nxt_state = ST_IDLE;
        else
          nxt_tmr = CW'(tmr_ff - 1'b1);
      end
      ST_IDLE:
      begin
        if (transfer_begin_sequence)
        begin
          nxt_state = ST_CMD;
          nxt_cnt = 4'h0;
        end
      end
      // shift in command, judge it after the eighth fall
      ST_CMD, ST_WR_BYTE:
      begin
        if (sck_rise)
        begin
          nxt_sh = {sh_ff[6:0], dat_s_ff};
          nxt_cnt = cnt_ff + 4'h1;
        end
        else if (sck_fall && cnt_ff == `THS_BYTE_BITS)
        begin
          if (state_ff == ST_WR_BYTE)
          begin
            nxt_oe = 1'b1;
            nxt_state = ST_WR_ACK;
          end
          else if (cmd_ok(sh_ff))
          begin
            nxt_oe = 1'b1;
            nxt_state = ST_CMD_ACK;
          end
          else
            nxt_state = ST_IDLE;
        end
      end
      // release after the ninth fall and dispatch
      ST_CMD_ACK:
      begin
        if (sck_fall)
        begin
          nxt_oe = 1'b0;
          nxt_ld_idx = 2'h0;
          case (sh_ff[4:0])
            `THS_CMD_HUM, `THS_CMD_TEMP:
            begin
              nxt_kind = (sh_ff[4:0] == `THS_CMD_HUM) ? MK_HUM : MK_TEMP;
              nxt_tmr = meas_cycles(nxt_kind, st_ff[`THS_ST_RES]);
              nxt_state = ST_MEAS;
            end
            `THS_CMD_STAT_RD:
            begin
              nxt_kind = MK_STAT;
              nxt_state = ST_LOAD;
            end
            `THS_CMD_STAT_WR:
            begin
              nxt_cnt = 4'h0;
              nxt_state = ST_WR_BYTE;
            end
            `THS_CMD_SOFT_RST:
            begin
              nxt_st = `THS_ST_DEFAULT;
              nxt_tmr = CW'(WAKE_CYC - 1);
              nxt_state = ST_WAKE;
            end
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_WR_ACK:
      begin
        if (sck_fall)
        begin
          nxt_oe = 1'b0;
          nxt_st = sh_ff[3:0];
          nxt_state = ST_IDLE;
        end
      end
      // conversion timer, then capture result and supply flag
      ST_MEAS:
      begin
        if (tmr_ff == '0)
        begin
          nxt_res = fmt_result(kind_ff, st_ff[`THS_ST_RES], hum_raw, tmp_raw);
          nxt_lowv = supply_low_in;
          nxt_state = ST_LOAD;
        end
        else
          nxt_tmr = CW'(tmr_ff - 1'b1);
      end
      ST_LOAD:
      begin
        if (q_if.wready)
        begin
          if (ld_idx_ff == ld_last)
            nxt_state = ST_FIRST;
          else
            nxt_ld_idx = ld_idx_ff + 2'h1;
        end
      end
      // first byte msb is always 0 here, so this is the data-ready low
      ST_FIRST:
      begin
        if (q_if.rvalid)
        begin
          q_rready = 1'b1;
          nxt_sh = q_if.rdata;
          nxt_oe = !q_if.rdata[7];
          nxt_cnt = 4'h0;
          nxt_state = ST_SEND;
        end
      end
      ST_SEND:
      begin
        if (sck_rise)
          nxt_cnt = cnt_ff + 4'h1;
        else if (sck_fall)
        begin
          if (cnt_ff == `THS_BYTE_BITS)
          begin
            nxt_oe = 1'b0;
            nxt_ack = 1'b0;
            nxt_state = ST_SEND_ACK;
          end
          else
          begin
            nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_oe = !sh_ff[6];
          end
        end
      end
      ST_SEND_ACK:
      begin
        if (sck_rise)
          nxt_ack = !dat_s_ff;
        else if (sck_fall)
        begin
          if (ack_ff && q_if.rvalid)
          begin
            q_rready = 1'b1;
            nxt_sh = q_if.rdata;
            nxt_oe = !q_if.rdata[7];
            nxt_cnt = 4'h0;
            nxt_state = ST_SEND;
          end
          else
          begin
            q_flush = 1'b1;
            nxt_kind = MK_NONE;
            nxt_state = ST_IDLE;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // interface reset leaves status bits alone
    if (crst_hit && state_ff != ST_WAKE && state_ff != ST_MEAS)
    begin
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
      nxt_kind = MK_NONE;
      q_rready = 1'b0;
      q_flush = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_ff <= ST_WAKE;
      tmr_ff <= CW'(WAKE_CYC - 1);
      st_ff <= `THS_ST_DEFAULT;
      lowv_ff <= `THS_LOWV_RESET;
      kind_ff <= MK_NONE;
      oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      ts_ph_ff <= 2'h0;
      crst_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      st_ff <= nxt_st;
      lowv_ff <= nxt_lowv;
      kind_ff <= nxt_kind;
      oe_ff <= nxt_oe;
      busy_ff <= (nxt_state == ST_MEAS);
      ts_ph_ff <= nxt_ts_ph;
      crst_ff <= nxt_crst;
    end
  end

  // datapath registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      res_ff <= 16'h0000;
      ld_idx_ff <= 2'h0;
      ack_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      res_ff <= nxt_res;
      ld_idx_ff <= nxt_ld_idx;
      ack_ff <= nxt_ack;
    end
  end

  // open drain: the pin only ever drives low
  always_ff @(posedge sys_clk)
  begin
    dout_ff <= 1'b0;
  end

  // ==========================================================
  // outputs, each a flop
  assign data_pin_out = dout_ff;
  assign data_pin_oe = oe_ff;
  assign heater_on = st_ff[`THS_ST_HEAT];
  assign otp_reload_off = st_ff[`THS_ST_OTP];
  assign res_low = st_ff[`THS_ST_RES];
  assign meas_busy = busy_ff;
  assign meas_kind = kind_ff;
endmodule

//--- src/ths_consts.svh
// named constants for the two-wire sensor command port
// assumes a 100 MHz system clock; included by bare name
`ifndef THS_CONSTS_SVH
`define THS_CONSTS_SVH

// ==========================================================
// clock and timing
`define THS_CLK_MHZ 100
`define THS_CYC_PER_MS (`THS_CLK_MHZ * 1000)
`define THS_T_WAKE_MS 11
`define THS_T_MEAS8_MS 20
`define THS_T_MEAS12_MS 80
`define THS_T_MEAS14_MS 320
`define THS_EARLY_MAX_PCT 30

// ==========================================================
// command byte
`define THS_ADDR_OK 3'h0
`define THS_CMD_TEMP 5'h03
`define THS_CMD_HUM 5'h05
`define THS_CMD_STAT_RD 5'h07
`define THS_CMD_STAT_WR 5'h06
`define THS_CMD_SOFT_RST 5'h1e

// ==========================================================
// status byte fields
`define THS_ST_RES 0
`define THS_ST_OTP 1
`define THS_ST_HEAT 2
`define THS_ST_TEST 3
`define THS_ST_LOWV 6
`define THS_ST_DEFAULT 4'h0
`define THS_LOWV_RESET 1'h0

// ==========================================================
// bit counting
`define THS_BYTE_BITS 4'h8
`define THS_CONN_RST_CNT 4'h9
`define THS_LD_LAST_MEAS 2'h2
`define THS_LD_LAST_STAT 2'h1

// ==========================================================
// buffer shape
`define THS_FIFO_WIDTH 8
`define THS_FIFO_DEPTH 16

`endif

//--- src/ths_pkg.sv
// types shared by the sensor command port modules
// assumes nothing beyond a SystemVerilog compiler
package ths_pkg;

  // ==========================================================
  // serial engine states
  typedef enum logic [3:0] {
    ST_WAKE,
    ST_IDLE,
    ST_CMD,
    ST_CMD_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_MEAS,
    ST_LOAD,
    ST_FIRST,
    ST_SEND,
    ST_SEND_ACK
  } ths_state_t;

  // ==========================================================
  // what the current transfer is about
  typedef enum logic [1:0] {
    MK_NONE,
    MK_HUM,
    MK_TEMP,
    MK_STAT
  } ths_meas_t;

endpackage

//--- src/ths_fifo_if.sv
// byte stream carrier between the serial engine and its buffer
// assumes both ends share sys_clk
`timescale 1ns/10ps

interface ths_fifo_if #(
  parameter int WIDTH = 8
);
  logic wvalid;
  logic wready;
  logic [WIDTH-1:0] wdata;
  logic rvalid;
  logic rready;
  logic [WIDTH-1:0] rdata;
  logic flush;

  // buffer side
  modport fill (
    input wvalid,
    input wdata,
    input rready,
    input flush,
    output wready,
    output rvalid,
    output rdata
  );

  // engine side
  modport user (
    output wvalid,
    output wdata,
    output rready,
    output flush,
    input wready,
    input rvalid,
    input rdata
  );
endinterface

//--- src/ths_fifo.sv
// show-ahead fifo holding readout bytes
// assumes synchronous active-high reset on sys_clk
`timescale 1ns/10ps

module ths_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // stream
  ths_fifo_if.fill q
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // shape checks
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_shape
      $error("ths_fifo: depth must be a power of two and width positive");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  wire full = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
  wire empty = (wptr_ff == rptr_ff);
  wire do_wr = q.wvalid && !full && !q.flush;
  wire do_rd = q.rready && !empty && !q.flush;

  // honest flags, head word always visible
  assign q.wready = !full; // no flush term, keeps the engine's next-state logic loop-free
  assign q.rvalid = !empty;
  assign q.rdata = mem[rptr_ff[AW-1:0]];

  // pointers, flush empties at once
  always_ff @(posedge sys_clk)
  begin
    if (rst || q.flush)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end
    else
    begin
      wptr_ff <= wptr_ff + (AW + 1)'(do_wr);
      rptr_ff <= rptr_ff + (AW + 1)'(do_rd);
    end
  end

  // storage
  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
      mem[wptr_ff[AW-1:0]] <= q.wdata;
  end
endmodule

//--- tb/ths_sensor_port_properties.sv
// concurrent checks on the pins of the sensor command port
// assumes bind onto ths_sensor_port, one clock domain
`timescale 1ns/10ps

module ths_sensor_port_props #(
  parameter int unsigned MEAS8_CYC = 200,
  parameter int unsigned MEAS12_CYC = 400,
  parameter int unsigned MEAS14_CYC = 800
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins
  input wire logic sck_pin,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  // status and activity
  input wire logic heater_on,
  input wire logic otp_reload_off,
  input wire logic res_low,
  input wire logic meas_busy,
  input wire ths_pkg::ths_meas_t meas_kind
);
  import ths_pkg::*;
  logic [6:0] sck_hist_ff;
  logic [7:0] busy_hist_ff;
  logic [31:0] cnt_ff;
  logic [31:0] lim_ff;
  logic [31:0] nxt_lim;

  // conversion length of the running kind
  assign nxt_lim = (meas_kind == MK_HUM) ? (res_low ? MEAS8_CYC : MEAS12_CYC) :
    (res_low ? MEAS12_CYC : MEAS14_CYC);

  // recent sck and busy levels, busy length
  always_ff @(posedge sys_clk)
  begin
    sck_hist_ff <= {sck_hist_ff[5:0], sck_pin};
    busy_hist_ff <= {busy_hist_ff[6:0], meas_busy};
    cnt_ff <= meas_busy ? cnt_ff + 32'h1 : 32'h0;
    lim_ff <= meas_busy ? nxt_lim : lim_ff;
  end

  // ==========================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_od_low;
    data_pin_out == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("data driven high");
  property p_rst_dflt;
    $fell(rst) |-> !data_pin_oe && !heater_on && !otp_reload_off && !res_low && !meas_busy;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("bad reset state");
  property p_oe_sck_low;
    $changed(data_pin_oe) |-> !sck_pin;
  endproperty
  a_oe_sck_low: assert property (p_oe_sck_low) else $error("data moved, sck high");
  property p_oe_fall;
    $fell(data_pin_oe) |-> (|sck_hist_ff[6:1]);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("release without sck");
  property p_oe_rise;
    $rose(data_pin_oe) |-> (|sck_hist_ff[6:1]) || (|busy_hist_ff);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("pull without cause");
  property p_busy_quiet;
    cnt_ff > 32'h28 |-> !data_pin_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("pull while busy");
  property p_ready;
    $fell(meas_busy) |-> ##[0:6] data_pin_oe;
  endproperty
  a_ready: assert property (p_ready) else $error("no data ready");
  property p_busy_len;
    $fell(meas_busy) |-> cnt_ff <= lim_ff + 32'h4 && cnt_ff * 32'ha + 32'h28 >= lim_ff * 32'h7;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("conversion length");
  property p_kind;
    meas_busy |-> meas_kind inside {MK_HUM, MK_TEMP};
  endproperty
  a_kind: assert property (p_kind) else $error("busy kind wrong");
  property p_stat_frozen;
    meas_busy |=> $stable({heater_on, otp_reload_off, res_low});
  endproperty
  a_stat_frozen: assert property (p_stat_frozen) else $error("status moved");
  c_ready: cover property ($fell(meas_busy));
  c_heat: cover property ($rose(heater_on));
  c_res: cover property ($fell(res_low));
endmodule

bind ths_sensor_port ths_sensor_port_props #(
  .MEAS8_CYC(MEAS8_CYC),
  .MEAS12_CYC(MEAS12_CYC),
  .MEAS14_CYC(MEAS14_CYC)
) i_props (
  .sys_clk(sys_clk),
  .rst(rst),
  .sck_pin(sck_pin),
  .data_pin_out(data_pin_out),
  .data_pin_oe(data_pin_oe),
  .heater_on(heater_on),
  .otp_reload_off(otp_reload_off),
  .res_low(res_low),
  .meas_busy(meas_busy),
  .meas_kind(meas_kind)
);

//--- tb/ths_host_model.sv
// host model: drives sck, only ever pulls the data wire low
// assumes the bench resolves data_w with a pull-up
`timescale 1ns/10ps

module ths_host_model (
  // clock
  input wire logic sys_clk,
  // link
  input wire logic data_w,
  output logic sck,
  output logic pull
);
  // idle link: sck low, wire released
  initial
  begin
    sck = 1'b0;
    pull = 1'b0;
  end
  // half of a 160 ns link period
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask
  // data falls and rises again under sck high
  task automatic start();
    sck = 1'b1;
    half();
    pull = 1'b1;
    half();
    sck = 1'b0;
    half();
    sck = 1'b1;
    half();
    pull = 1'b0;
    half();
    sck = 1'b0;
  endtask
  // bit set while sck low, read just before sck falls
  task automatic bit_io(input logic tx, output logic rx);
    pull = ~tx;
    half();
    sck = 1'b1;
    half();
    rx = data_w;
    sck = 1'b0;
  endtask
  // one byte, msb first
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
  endtask
  // let go of the wire for a half period
  task automatic idle();
    pull = 1'b0;
    half();
  endtask
endmodule

//--- tb/ths_sensor_port_tb.sv
// self-checking bench: host model on the pins, short counts
// assumes the checker binds itself from its own file
`timescale 1ns/10ps

module ths_sensor_port_tb;
  import ths_pkg::*;
  localparam int unsigned WAKE = 50;
  logic sys_clk;
  logic rst;
  logic sck;
  logic pull;
  logic data_pin_out;
  logic data_pin_oe;
  logic [13:0] tmp_raw;
  logic [11:0] hum_raw;
  logic supply_low_in;
  logic [7:0] checksum_in;
  logic heater_on;
  logic otp_reload_off;
  logic res_low;
  logic meas_busy;
  ths_meas_t meas_kind;
  int error_cnt;
  int n_tests;
  int cyc;
  wire logic data_w;

  // open-drain wire with pull-up
  assign data_w = (data_pin_oe ? data_pin_out : 1'b1) & ~pull;

  ths_sensor_port #(
    .WAKE_CYC(WAKE),
    .MEAS8_CYC(200),
    .MEAS12_CYC(400),
    .MEAS14_CYC(800),
    .EARLY_PCT(0),
    .FIFO_DEPTH(16)
  ) i_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .sck_pin(sck),
    .data_pin_in(data_w),
    .data_pin_out(data_pin_out),
    .data_pin_oe(data_pin_oe),
    .tmp_raw(tmp_raw),
    .hum_raw(hum_raw),
    .supply_low_in(supply_low_in),
    .checksum_in(checksum_in),
    .heater_on(heater_on),
    .otp_reload_off(otp_reload_off),
    .res_low(res_low),
    .meas_busy(meas_busy),
    .meas_kind(meas_kind)
  );

  ths_host_model i_host (
    .sys_clk(sys_clk),
    .data_w(data_w),
    .sck(sck),
    .pull(pull)
  );

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // start, command byte, ack bit; low ack means accepted
  task automatic cmd(input logic [7:0] c, output logic ack);
    logic [7:0] r;
    i_host.start();
    i_host.byte_io(c, r);
    i_host.bit_io(1'b1, ack);
    i_host.idle();
  endtask

  task automatic stat_wr(input logic [7:0] v);
    logic a;
    logic [7:0] r;
    cmd(8'h06, a);
    chk({15'h0, a}, 16'h0);
    i_host.byte_io(v, r);
    i_host.bit_io(1'b1, a);
    chk({15'h0, a}, 16'h0);
    i_host.idle();
  endtask

  task automatic stat_rd(input logic [7:0] exp);
    logic a;
    logic [7:0] r;
    cmd(8'h07, a);
    chk({15'h0, a}, 16'h0);
    i_host.byte_io(8'hff, r);
    chk({8'h0, r}, {8'h0, exp});
    i_host.bit_io(1'b0, a);
    i_host.byte_io(8'hff, r);
    chk({8'h0, r}, {8'h0, checksum_in});
    i_host.bit_io(1'b1, a);
    i_host.idle();
  endtask

  // conversion, late readout, full or cut short after the low byte
  task automatic measure(input logic [7:0] c, input logic [15:0] exp, input logic full);
    logic a;
    logic [7:0] hi;
    logic [7:0] lo;
    int n;
    cmd(c, a);
    chk({15'h0, a}, 16'h0);
    chk({15'h0, meas_busy}, 16'h1);
    chk({14'h0, meas_kind}, {14'h0, ((c == 8'h05) ? MK_HUM : MK_TEMP)});
    n = 0;
    while (data_w !== 1'b0 && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
    repeat (100) @(negedge sys_clk);
    chk({15'h0, data_w}, 16'h0);
    chk({15'h0, meas_busy}, 16'h0);
    i_host.byte_io(8'hff, hi);
    i_host.bit_io(1'b0, a);
    i_host.byte_io(8'hff, lo);
    chk({hi, lo}, exp);
    i_host.bit_io(~full, a);
    if (full)
    begin
      i_host.byte_io(8'hff, hi);
      chk({8'h0, hi}, {8'h0, checksum_in});
      i_host.bit_io(1'b0, a);
    end
    i_host.idle();
    repeat (4) @(negedge sys_clk);
    chk({14'h0, meas_kind}, {14'h0, MK_NONE});
    // rest nine times the conversion so the sensor stays active a tenth of the time
    repeat (9 * n) @(negedge sys_clk);
  endtask

  task automatic t_defaults();
    chk({13'h0, heater_on, otp_reload_off, res_low}, 16'h0);
    stat_rd(8'h00);
  endtask

  task automatic t_status();
    stat_wr(8'h07);
    chk({13'h0, heater_on, otp_reload_off, res_low}, 16'h7);
    stat_rd(8'h07);
  endtask

  task automatic t_meas();
    measure(8'h05, {8'h0, hum_raw[11:4]}, 1'b1);
    measure(8'h03, {4'h0, tmp_raw[13:2]}, 1'b0);
    stat_rd(8'h47);
    stat_wr(8'h00);
    measure(8'h05, {4'h0, hum_raw}, 1'b0);
    measure(8'h03, {2'h0, tmp_raw}, 1'b1);
  endtask

  // interface reset after a rejected command byte keeps the status byte
  task automatic t_conn_reset();
    logic a;
    stat_wr(8'h05);
    i_host.start();
    for (int i = 0; i < 4; i++)
      i_host.bit_io(1'b0, a);
    for (int i = 0; i < 9; i++)
      i_host.bit_io(1'b1, a);
    i_host.idle();
    stat_rd(8'h45);
  endtask

  task automatic t_bad();
    logic a;
    cmd(8'h25, a);
    chk({15'h0, a}, 16'h1);
    cmd(8'h01, a);
    chk({15'h0, a}, 16'h1);
    stat_rd(8'h45);
  endtask

  task automatic t_soft_reset();
    logic a;
    cmd(8'h1e, a);
    chk({15'h0, a}, 16'h0);
    repeat (WAKE + 10) @(negedge sys_clk);
    chk({13'h0, heater_on, otp_reload_off, res_low}, 16'h0);
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    tmp_raw = 14'h2a5b;
    hum_raw = 12'h931;
    supply_low_in = 1'b1;
    checksum_in = 8'h5a;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    repeat (WAKE + 10) @(negedge sys_clk);
    t_defaults();
    t_status();
    t_meas();
    t_conn_reset();
    t_bad();
    t_soft_reset();
    stop_test();
  end
endmodule
